// ---- include/clk_sel_pkg.sv ----
// constants, command codes and device register map for the clock host
// How it works
// RQ1: wait until stabilization-done reads 1 before using the main oscillator.
// RQ2: after clearing subclock-select, poll cpu-on-subclock status until it reads 0.
// RQ3: change subclock-select by read-modify-write, keeping the three divider bits.
// RQ4: main-clock users are enabled only after stabilization has finished.
// RQ5: internal oscillator mode register is 8 bits and resets to 80H.
// RQ6: hs_osc_running reads 1 while the 8 MHz oscillator runs.
// RQ7: hs_osc_stop 0 keeps the high-speed oscillator running, 1 stops it.
// RQ8: ls_osc_stop 0 keeps the 240 kHz oscillator running, 1 stops it.
// RQ9: never stop an internal oscillator the CPU currently runs from.
// RQ10: fall-back forces the low-speed oscillator on; its stop bit still reads 1.
// RQ11: main clock mode register resets 00H; write only right after unlock write.
// RQ12: main_source_status reads 0 on internal oscillator, 1 on external.
// RQ13: main_source_select 0 picks internal 8 MHz, 1 picks external oscillator.
// RQ14: change main_source_select only in clock-through mode, never on subclock.
// RQ15: never write main clock mode while the chosen oscillator is unstable.
// RQ16: during low-speed fall-back never set main_source_select to 1.
// RQ17: cpu clock status resets 00H; fall-back flag 1 means 240 kHz operation.
// RQ18: watchdog overflow during stabilization sets fall-back; status reads 01H.
// RQ19: prog_out_enable 0 holds the pin low, 1 drives the divided clock.
// RQ20: two-bit divider field selects divide by 4, 8, 16 or 32.
// RQ21: set prog_out_enable only while the PLL runs; clear before stopping it.
// RQ22: CPU clock is subclock, else multiplier output, else main source.
// RQ23: cpu_on_subclock_status reads 0 on main clock, 1 on subclock.
// RQ24: low three divider bits pick main clock divided by 1 to 32.
// RQ25: clock multiplexers change over only at clean edges, glitch free.
package clk_sel_pkg;
  // device register indices on the device access port
  localparam logic [3:0] DEV_PCC = 4'h0;
  localparam logic [3:0] DEV_RCM = 4'h1;
  localparam logic [3:0] DEV_MCM = 4'h2;
  localparam logic [3:0] DEV_CPU_CLOCK_STATUS = 4'h3;
  localparam logic [3:0] DEV_PROG_CLOCK_OUT_MODE = 4'h4;
  localparam logic [3:0] DEV_MULTIPLIER_CONTROL = 4'h5;
  localparam logic [3:0] DEV_STABILIZATION_COUNT_STATUS = 4'h7;
  localparam logic [3:0] DEV_UNLOCK = 4'h8;
  // key written to protect_unlock_cmd; value is arbitrary
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  // device reset values
  localparam logic [7:0] PCC_RST = 8'h40;
  localparam logic [7:0] RCM_RST = 8'h80;
  localparam logic [7:0] MCM_RST = 8'h00;
  localparam logic [7:0] CPU_CLOCK_STATUS_RST = 8'h00;
  // field positions
  localparam int PCC_MCK = 6;
  localparam int PCC_CLS = 4;
  localparam int PCC_CK3 = 3;
  localparam int RCM_HS_OSC_RUNNING = 7;
  localparam int RCM_HSTOP = 1;
  localparam int RCM_LSTOP = 0;
  localparam int MCM_MCS = 1;
  localparam int MCM_SEL = 0;
  localparam int CPU_CLOCK_STATUS_FB = 0;
  localparam int PROG_CLOCK_OUT_MODE_EN = 4;
  localparam int PLL_ON = 0;
  localparam int PLL_SEL = 1;
  localparam int STABILIZATION_COUNT_STATUS_DONE = 0;
  // gather order: shadow index 0..5
  localparam int NGATHER = 6;
  localparam logic [2:0] SH_PCC = 3'h0;
  localparam logic [2:0] SH_RCM = 3'h1;
  localparam logic [2:0] SH_MCM = 3'h2;
  localparam logic [2:0] SH_CPU_CLOCK_STATUS = 3'h3;
  localparam logic [2:0] SH_PLL = 3'h4;
  localparam logic [2:0] SH_STABILIZATION_COUNT_STATUS = 3'h5;
  // wishbone byte offsets
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_SNAP = 8'h08;
  localparam logic [7:0] WB_SNAP2 = 8'h0C;
  // error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_MODE = 4'h1;
  localparam logic [3:0] ERR_FALLBACK = 4'h2;
  localparam logic [3:0] ERR_UNSTABLE = 4'h3;
  localparam logic [3:0] ERR_INUSE = 4'h4;
  localparam logic [3:0] ERR_NOPLL = 4'h5;
  localparam logic [3:0] ERR_BADCMD = 4'h6;
  typedef enum logic [3:0] {
    CMD_MAIN_ON = 4'h1,
    CMD_SEL_SRC = 4'h2,
    CMD_TO_SUB = 4'h3,
    CMD_TO_MAIN = 4'h4,
    CMD_HS_STOP = 4'h5,
    CMD_LS_STOP = 4'h6,
    CMD_PCL_SET = 4'h7
  } cmd_t;
endpackage : clk_sel_pkg

// ---- design/wb_cmd_regs.sv ----
// wishbone classic slave holding the command, status and snapshot words
`timescale 1ns/1ns
module wb_cmd_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cmdGo,
  output logic [3:0] cmdCode,
  output logic [2:0] cmdArg,
  input wire logic busy,
  input wire logic [15:0] status,
  input wire logic [31:0] snap,
  input wire logic [31:0] snap2
);
  logic take;
  logic [31:0] rdNext;

  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb begin
    unique case (wb_adr_i)
      clk_sel_pkg::WB_STAT: rdNext = {15'h0000, busy, status};
      clk_sel_pkg::WB_SNAP: rdNext = snap;
      clk_sel_pkg::WB_SNAP2: rdNext = snap2;
      default: rdNext = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= take;
      if (take && !wb_we_i) begin
        wb_dat_o <= rdNext;
      end
    end
  end

  // a command written while busy is dropped; status keeps the old one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdGo <= 1'b0;
      cmdCode <= 4'h0;
      cmdArg <= 3'h0;
    end else begin
      cmdGo <= 1'b0;
      if (take && wb_we_i && wb_adr_i == clk_sel_pkg::WB_CMD
          && wb_sel_i[1:0] == 2'h3 && !busy) begin
        cmdGo <= 1'b1;
        cmdCode <= wb_dat_i[3:0];
        cmdArg <= wb_dat_i[10:8];
      end
    end
  end
endmodule : wb_cmd_regs

// ---- design/dev_access.sv ----
// four-phase register access to the device over its strobe/ack pins
`timescale 1ns/1ns
module dev_access (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] data,
  output logic done,
  output logic [7:0] rdData,
  output logic [3:0] devAddr,
  output logic [7:0] devWrData,
  output logic devWrStb,
  output logic devRdStb,
  input wire logic [7:0] devRdData,
  input wire logic devAck
);
  logic ackMeta;
  logic ackSync;
  logic [7:0] rdMeta;
  logic [7:0] rdSync;
  logic waitLow;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
      rdMeta <= 8'h00;
      rdSync <= 8'h00;
    end else begin
      ackMeta <= devAck;
      ackSync <= ackMeta;
      rdMeta <= devRdData;
      rdSync <= rdMeta;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      devAddr <= 4'h0;
      devWrData <= 8'h00;
      devWrStb <= 1'b0;
      devRdStb <= 1'b0;
      waitLow <= 1'b0;
      done <= 1'b0;
      rdData <= 8'h00;
    end else begin
      done <= 1'b0;
      if (go && !devWrStb && !devRdStb && !waitLow) begin
        devAddr <= addr;
        devWrData <= data;
        devWrStb <= wr;
        devRdStb <= ~wr;
      end else if ((devWrStb || devRdStb) && ackSync) begin
        rdData <= rdSync;
        devWrStb <= 1'b0;
        devRdStb <= 1'b0;
        waitLow <= 1'b1;
      end else if (waitLow && !ackSync) begin
        waitLow <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : dev_access

// ---- design/clock_source_host.sv ----
// host sequencer driving the clock source selector through its registers
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module clock_source_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [3:0] devAddr,
  output logic [7:0] devWrData,
  output logic devWrStb,
  output logic devRdStb,
  input wire logic [7:0] devRdData,
  input wire logic devAck
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GATHER = 3'b001,
    ST_CHECK = 3'b010,
    ST_UNLOCK = 3'b011,
    ST_WRITE = 3'b100,
    ST_POLL = 3'b101,
    ST_DONE = 3'b110
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic cmdGo;
  logic [3:0] cmdCode;
  logic [2:0] cmdArg;
  logic [3:0] code_reg;
  logic [2:0] arg_reg;
  logic [2:0] gIdx_reg;
  logic [7:0] shadow_reg [0:5];
  logic [7:0] prog_clock_out_mode_reg;
  logic issued_reg;
  logic devGo;
  logic devWr;
  logic [3:0] devSel;
  logic [7:0] devData;
  logic devDone;
  logic [7:0] devRd;
  logic [3:0] err_reg;
  logic refused_reg;
  logic [7:0] lastRead_reg;
  logic lastUnlock_reg;
  logic busy;

  // decisions taken from the gathered shadows
  logic refuse;
  logic [3:0] errCode;
  logic [3:0] tgtAddr;
  logic [7:0] wrVal;
  logic needUnlock;
  logic [3:0] pollAddr;
  logic [7:0] pollMask;
  logic [7:0] pollVal;

  logic [7:0] processor_clock_control;
  logic [7:0] internal_osc_mode;
  logic [7:0] main_clock_mode;
  logic [7:0] cpu_clock_status;
  logic [7:0] pll;
  logic [7:0] stabilization_count_status;
  logic stable;
  logic onHs;
  logic pollOk;

  assign processor_clock_control = shadow_reg[clk_sel_pkg::SH_PCC];
  assign internal_osc_mode = shadow_reg[clk_sel_pkg::SH_RCM];
  assign main_clock_mode = shadow_reg[clk_sel_pkg::SH_MCM];
  assign cpu_clock_status = shadow_reg[clk_sel_pkg::SH_CPU_CLOCK_STATUS];
  assign pll = shadow_reg[clk_sel_pkg::SH_PLL];
  assign stabilization_count_status = shadow_reg[clk_sel_pkg::SH_STABILIZATION_COUNT_STATUS];
  assign stable = stabilization_count_status[clk_sel_pkg::STABILIZATION_COUNT_STATUS_DONE];
  // CPU on the 8 MHz internal source: main clock, internal, no fall-back
  assign onHs = !processor_clock_control[clk_sel_pkg::PCC_CK3] && !main_clock_mode[clk_sel_pkg::MCM_MCS]
                && !cpu_clock_status[clk_sel_pkg::CPU_CLOCK_STATUS_FB]; // RQ22
  assign busy = state_reg != ST_IDLE;
  assign pollOk = (devRd & pollMask) == pollVal;

  wb_cmd_regs u_regs (
    .clk(clk),
    .reset(reset),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .cmdGo(cmdGo),
    .cmdCode(cmdCode),
    .cmdArg(cmdArg),
    .busy(busy),
    .status({4'h0, code_reg, err_reg, 3'h0, refused_reg}),
    .snap({cpu_clock_status, main_clock_mode, internal_osc_mode, processor_clock_control}),
    .snap2({8'h00, prog_clock_out_mode_reg, stabilization_count_status, pll})
  );

  dev_access u_dev (
    .clk(clk),
    .reset(reset),
    .go(devGo),
    .wr(devWr),
    .addr(devSel),
    .data(devData),
    .done(devDone),
    .rdData(devRd),
    .devAddr(devAddr),
    .devWrData(devWrData),
    .devWrStb(devWrStb),
    .devRdStb(devRdStb),
    .devRdData(devRdData),
    .devAck(devAck)
  );

  always_comb begin
    refuse = 1'b0;
    errCode = clk_sel_pkg::ERR_NONE;
    tgtAddr = clk_sel_pkg::DEV_PCC;
    wrVal = processor_clock_control;
    needUnlock = 1'b0;
    pollAddr = clk_sel_pkg::DEV_PCC;
    pollMask = 8'h00;
    pollVal = 8'h00;
    unique case (code_reg)
      clk_sel_pkg::CMD_MAIN_ON: begin
        wrVal = processor_clock_control & ~(8'h01 << clk_sel_pkg::PCC_MCK);
        needUnlock = 1'b1;
        // done only once stabilization has elapsed
        pollAddr = clk_sel_pkg::DEV_STABILIZATION_COUNT_STATUS; // RQ1
        pollMask = 8'h01 << clk_sel_pkg::STABILIZATION_COUNT_STATUS_DONE;
        pollVal = pollMask;
      end
      clk_sel_pkg::CMD_SEL_SRC: begin
        tgtAddr = clk_sel_pkg::DEV_MCM;
        wrVal = (main_clock_mode & ~(8'h01 << clk_sel_pkg::MCM_SEL))
                | {7'h00, arg_reg[0]}; // RQ13
        needUnlock = 1'b1; // RQ11
        pollAddr = clk_sel_pkg::DEV_MCM;
        pollMask = 8'h01 << clk_sel_pkg::MCM_MCS;
        pollVal = arg_reg[0] ? pollMask : 8'h00; // RQ12
        if (pll[clk_sel_pkg::PLL_SEL] || processor_clock_control[clk_sel_pkg::PCC_CK3]) begin
          refuse = 1'b1; // RQ14
          errCode = clk_sel_pkg::ERR_MODE;
        end else if (arg_reg[0] && cpu_clock_status[clk_sel_pkg::CPU_CLOCK_STATUS_FB]) begin
          refuse = 1'b1; // RQ16
          errCode = clk_sel_pkg::ERR_FALLBACK;
        end else if (arg_reg[0] ? !stable
                     : !internal_osc_mode[clk_sel_pkg::RCM_HS_OSC_RUNNING]) begin
          refuse = 1'b1; // RQ15
          errCode = clk_sel_pkg::ERR_UNSTABLE;
        end
      end
      clk_sel_pkg::CMD_TO_SUB: begin
        // only bit 3 changes, divider bits ride through
        wrVal = processor_clock_control | (8'h01 << clk_sel_pkg::PCC_CK3); // RQ3 RQ24
        needUnlock = 1'b1;
        pollMask = 8'h01 << clk_sel_pkg::PCC_CLS; // RQ23
        pollVal = pollMask;
        if (!main_clock_mode[clk_sel_pkg::MCM_MCS]) begin
          refuse = 1'b1;
          errCode = clk_sel_pkg::ERR_MODE;
        end
      end
      clk_sel_pkg::CMD_TO_MAIN: begin
        wrVal = processor_clock_control & ~(8'h01 << clk_sel_pkg::PCC_CK3); // RQ3
        needUnlock = 1'b1;
        // wait for the switch instead of assuming a subclock period
        pollMask = 8'h01 << clk_sel_pkg::PCC_CLS; // RQ2 RQ25
        pollVal = 8'h00;
        if (!stable) begin
          refuse = 1'b1; // RQ4
          errCode = clk_sel_pkg::ERR_UNSTABLE;
        end
      end
      clk_sel_pkg::CMD_HS_STOP: begin
        tgtAddr = clk_sel_pkg::DEV_RCM;
        wrVal = (internal_osc_mode & ~(8'h01 << clk_sel_pkg::RCM_HSTOP))
                | ({7'h00, arg_reg[0]} << clk_sel_pkg::RCM_HSTOP); // RQ7
        pollAddr = clk_sel_pkg::DEV_RCM;
        pollMask = 8'h01 << clk_sel_pkg::RCM_HS_OSC_RUNNING; // RQ6
        pollVal = arg_reg[0] ? 8'h00 : pollMask;
        if (arg_reg[0] && onHs) begin
          refuse = 1'b1; // RQ9
          errCode = clk_sel_pkg::ERR_INUSE;
        end
      end
      clk_sel_pkg::CMD_LS_STOP: begin
        tgtAddr = clk_sel_pkg::DEV_RCM;
        // no poll: under fall-back the stop bit reads 1 yet it runs
        wrVal = (internal_osc_mode & ~(8'h01 << clk_sel_pkg::RCM_LSTOP))
                | {7'h00, arg_reg[0]}; // RQ8 RQ10
        if (arg_reg[0] && cpu_clock_status[clk_sel_pkg::CPU_CLOCK_STATUS_FB]) begin
          refuse = 1'b1; // RQ9
          errCode = clk_sel_pkg::ERR_INUSE;
        end
      end
      clk_sel_pkg::CMD_PCL_SET: begin
        tgtAddr = clk_sel_pkg::DEV_PROG_CLOCK_OUT_MODE;
        wrVal = ({7'h00, arg_reg[2]} << clk_sel_pkg::PROG_CLOCK_OUT_MODE_EN)
                | {6'h00, arg_reg[1:0]}; // RQ19 RQ20
        if (arg_reg[2] && !pll[clk_sel_pkg::PLL_ON]) begin
          refuse = 1'b1; // RQ21
          errCode = clk_sel_pkg::ERR_NOPLL;
        end
      end
      default: begin
        refuse = 1'b1;
        errCode = clk_sel_pkg::ERR_BADCMD;
      end
    endcase
  end

  // device access request for the current state
  always_comb begin
    devGo = 1'b0;
    devWr = 1'b0;
    devSel = clk_sel_pkg::DEV_PCC;
    devData = 8'h00;
    unique case (state_reg)
      ST_GATHER: begin
        devGo = !issued_reg;
        unique case (gIdx_reg)
          clk_sel_pkg::SH_RCM: devSel = clk_sel_pkg::DEV_RCM;
          clk_sel_pkg::SH_MCM: devSel = clk_sel_pkg::DEV_MCM;
          clk_sel_pkg::SH_CPU_CLOCK_STATUS: devSel = clk_sel_pkg::DEV_CPU_CLOCK_STATUS;
          clk_sel_pkg::SH_PLL: devSel = clk_sel_pkg::DEV_MULTIPLIER_CONTROL;
          clk_sel_pkg::SH_STABILIZATION_COUNT_STATUS: devSel = clk_sel_pkg::DEV_STABILIZATION_COUNT_STATUS;
          default: devSel = clk_sel_pkg::DEV_PCC;
        endcase
      end
      ST_UNLOCK: begin
        devGo = !issued_reg;
        devWr = 1'b1;
        devSel = clk_sel_pkg::DEV_UNLOCK;
        devData = clk_sel_pkg::UNLOCK_KEY;
      end
      ST_WRITE: begin
        devGo = !issued_reg;
        devWr = 1'b1;
        devSel = tgtAddr;
        devData = wrVal;
      end
      ST_POLL: begin
        devGo = !issued_reg;
        devSel = pollAddr;
      end
      default: begin
        devGo = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmdGo) begin
          state_next = ST_GATHER;
        end
      end
      ST_GATHER: begin
        if (devDone && gIdx_reg == 3'(clk_sel_pkg::NGATHER - 1)) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (refuse) begin
          state_next = ST_DONE;
        end else if (needUnlock) begin
          state_next = ST_UNLOCK;
        end else begin
          state_next = ST_WRITE;
        end
      end
      ST_UNLOCK: begin
        if (devDone) begin
          state_next = ST_WRITE; // RQ11
        end
      end
      ST_WRITE: begin
        if (devDone) begin
          state_next = (pollMask == 8'h00) ? ST_DONE : ST_POLL;
        end
      end
      ST_POLL: begin
        if (devDone && pollOk) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      issued_reg <= 1'b0;
    end else if (devDone) begin
      issued_reg <= 1'b0;
    end else if (devGo) begin
      issued_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gIdx_reg <= 3'h0;
    end else if (state_reg == ST_IDLE) begin
      gIdx_reg <= 3'h0;
    end else if (state_reg == ST_GATHER && devDone) begin
      gIdx_reg <= gIdx_reg + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      code_reg <= 4'h0;
      arg_reg <= 3'h0;
    end else if (state_reg == ST_IDLE && cmdGo) begin
      code_reg <= cmdCode;
      arg_reg <= cmdArg;
    end
  end

  // shadow copies start at the device reset values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow_reg[clk_sel_pkg::SH_PCC] <= clk_sel_pkg::PCC_RST;
      shadow_reg[clk_sel_pkg::SH_RCM] <= clk_sel_pkg::RCM_RST; // RQ5
      shadow_reg[clk_sel_pkg::SH_MCM] <= clk_sel_pkg::MCM_RST;
      shadow_reg[clk_sel_pkg::SH_CPU_CLOCK_STATUS] <= clk_sel_pkg::CPU_CLOCK_STATUS_RST; // RQ17
      shadow_reg[clk_sel_pkg::SH_PLL] <= 8'h00;
      shadow_reg[clk_sel_pkg::SH_STABILIZATION_COUNT_STATUS] <= 8'h00;
    end else if (state_reg == ST_GATHER && devDone) begin
      shadow_reg[gIdx_reg] <= devRd; // RQ18
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_clock_out_mode_reg <= 8'h00;
    end else if (state_reg == ST_WRITE && devDone
                 && tgtAddr == clk_sel_pkg::DEV_PROG_CLOCK_OUT_MODE) begin
      prog_clock_out_mode_reg <= wrVal;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_reg <= clk_sel_pkg::ERR_NONE;
      refused_reg <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      err_reg <= errCode;
      refused_reg <= refuse;
    end
  end

  // helpers watched by the checks below
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lastUnlock_reg <= 1'b0;
      lastRead_reg <= 8'h00;
    end else if (devDone) begin
      lastUnlock_reg <= state_reg == ST_UNLOCK;
      lastRead_reg <= devRd;
    end
  end

  unlock_before_write_a: assert property ( // RQ11
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && (devAddr == clk_sel_pkg::DEV_MCM
      || devAddr == clk_sel_pkg::DEV_PCC) |-> lastUnlock_reg)
    else $error("protected write without unlock just before");

  divider_bits_kept_a: assert property ( // RQ3
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && devAddr == clk_sel_pkg::DEV_PCC
    |-> devWrData[2:0] == processor_clock_control[2:0])
    else $error("divider select bits changed by clock switch");

  source_mode_guard_a: assert property ( // RQ14
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && devAddr == clk_sel_pkg::DEV_MCM
    |-> !pll[clk_sel_pkg::PLL_SEL] && !processor_clock_control[clk_sel_pkg::PCC_CK3])
    else $error("source select written outside clock-through");

  fallback_source_guard_a: assert property ( // RQ16
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && devAddr == clk_sel_pkg::DEV_MCM
    && devWrData[clk_sel_pkg::MCM_SEL] |-> !cpu_clock_status[clk_sel_pkg::CPU_CLOCK_STATUS_FB])
    else $error("external source selected during fall-back");

  stable_source_guard_a: assert property ( // RQ15
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && devAddr == clk_sel_pkg::DEV_MCM
    |-> (devWrData[clk_sel_pkg::MCM_SEL] ? stable
         : internal_osc_mode[clk_sel_pkg::RCM_HS_OSC_RUNNING]))
    else $error("source selected before it stabilized");

  hs_stop_guard_a: assert property ( // RQ9
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && code_reg == clk_sel_pkg::CMD_HS_STOP
    && devWrData[clk_sel_pkg::RCM_HSTOP] |-> !onHs)
    else $error("high-speed oscillator stopped while in use");

  ls_stop_guard_a: assert property ( // RQ9
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && code_reg == clk_sel_pkg::CMD_LS_STOP
    && devWrData[clk_sel_pkg::RCM_LSTOP] |-> !cpu_clock_status[clk_sel_pkg::CPU_CLOCK_STATUS_FB])
    else $error("low-speed oscillator stopped while in use");

  pcl_pll_guard_a: assert property ( // RQ21
    @(posedge clk) disable iff (reset)
    $rose(devWrStb) && devAddr == clk_sel_pkg::DEV_PROG_CLOCK_OUT_MODE
    && devWrData[clk_sel_pkg::PROG_CLOCK_OUT_MODE_EN] |-> pll[clk_sel_pkg::PLL_ON])
    else $error("clock output enabled without PLL running");

  main_on_done_a: assert property ( // RQ1
    @(posedge clk) disable iff (reset)
    state_reg == ST_DONE && code_reg == clk_sel_pkg::CMD_MAIN_ON
    && !refused_reg |-> lastRead_reg[clk_sel_pkg::STABILIZATION_COUNT_STATUS_DONE])
    else $error("main oscillator reported ready before stabilization");

  to_main_stable_a: assert property ( // RQ4
    @(posedge clk) disable iff (reset)
    state_reg == ST_CHECK && code_reg == clk_sel_pkg::CMD_TO_MAIN
    && !stable |=> state_reg == ST_DONE ##1 state_reg == ST_IDLE)
    else $error("switch to main clock before stabilization");

  to_main_confirm_a: assert property ( // RQ2
    @(posedge clk) disable iff (reset)
    state_reg == ST_DONE && code_reg == clk_sel_pkg::CMD_TO_MAIN
    && !refused_reg |-> !lastRead_reg[clk_sel_pkg::PCC_CLS])
    else $error("main clock switch not confirmed by status");

  bus_ack_pulse_a: assert property (
    @(posedge clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");
endmodule : clock_source_host

// ---- verif/clock_device_model.sv ----
// device model: clock register file answering the four-phase link
`timescale 1ns/1ns
module clock_device_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] devAddr,
  input wire logic [7:0] devWrData,
  input wire logic devWrStb,
  input wire logic devRdStb,
  output logic [7:0] devRdData,
  output logic devAck,
  input wire logic [1:0] lag,
  input wire logic [1:0] pll,
  input wire logic wdtOverflow
);
  logic [7:0] r [0:15];
  logic [1:0] dly;
  logic unl;
  logic onHs;
  logic [7:0] d;
  assign d = devWrData;
  assign onHs = !r[0][3] && !r[2][1] && !r[3][0];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) r[i] <= 8'h00;
      r[0] <= 8'h40;
      r[1] <= 8'h80;
      {devAck, devRdData, dly, unl} <= '0;
    end else begin
      r[5] <= {6'h00, pll};
      if (wdtOverflow) r[3] <= 8'h01;
      if (!devWrStb && !devRdStb) begin
        devAck <= 1'b0;
        // released data line no longer shows the last byte
        if (devAck) devRdData <= ~devRdData;
      end else if (!devAck && dly != lag) dly <= dly + 2'h1;
      else if (!devAck) begin
        devAck <= 1'b1;
        dly <= 2'h0;
        devRdData <= r[devAddr];
        if (devWrStb) begin
          unl <= devAddr == 4'h8 && d == clk_sel_pkg::UNLOCK_KEY;
          case (devAddr)
            4'h0: if (unl) begin
              r[0] <= {d[7:5], d[3], d[3:0]};
              r[7] <= {7'h00, !d[6]};
            end
            4'h1: r[1] <= {!d[1] || onHs, d[6:0]};
            4'h2: if (unl) r[2] <= {6'h00, d[0], d[0]};
            4'h4: r[4] <= d;
            default: ;
          endcase
        end
      end
    end
  end
endmodule : clock_device_model

// ---- verif/test_clock_source_host.sv ----
// self-checking bench for the clock source host
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_clock_source_host;
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic devWrStb, devRdStb, devAck, wdt;
  logic [7:0] wb_adr_i, devWrData, devRdData;
  logic [3:0] wb_sel_i, devAddr;
  logic [31:0] wb_dat_i, wb_dat_o, rdv, m, e;
  logic [1:0] lag, pll;
  logic [31:0] mq[$], eq[$];
  int n_errors, num_checks, cycles;
  clock_source_host u_clock_source_host (.clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .devAddr,
    .devWrData, .devWrStb, .devRdStb, .devRdData, .devAck);
  clock_device_model u_clock_device_model (.clk, .reset, .devAddr, .devWrData,
    .devWrStb, .devRdStb, .devRdData, .devAck, .lag, .pll, .wdtOverflow(wdt));
  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] mk, input logic [31:0] ex);
    if (!w) begin
      mq.push_back(mk);
      eq.push_back(ex);
    end
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rdv = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk);
  endtask : wb
  task automatic cmd(input logic [3:0] c, input logic [2:0] g,
      input logic [3:0] er);
    lag <= 2'($urandom);
    wb(1'b1, 8'h00, {21'h0, g, 4'h0, c}, 0, 0);
    do wb(1'b0, 8'h04, 0, 0, 0); while (rdv[16] !== 1'b0);
    wb(1'b0, 8'h04, 0, 32'h0001_0FF1, {20'h0, c, er, 3'h0, |er});
  endtask : cmd
  // the monitor pairs each read answer with the oldest noted expectation
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
    if (wb_ack_o === 1'b1 && !wb_we_i && mq.size() > 0) begin
      m = mq.pop_front();
      e = eq.pop_front();
      if (m != 0) `CHK(wb_dat_o & m, e)
    end
  end
  initial forever #25 clk = ~clk;
  initial begin
    {clk, reset} = 2'b01;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {wb_sel_i, pll, wdt} = 7'h78;
    lag = 2'($urandom(73650));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    cmd(4'h4, 3'h0, 4'h3);
    cmd(4'h2, 3'h1, 4'h3);
    cmd(4'h1, 3'h0, 4'h0);
    wb(1'b0, 8'h08, 0, '1, 32'h0000_8040);
    cmd(4'h2, 3'h1, 4'h0);
    wb(1'b0, 8'h0C, 0, '1, 32'h0000_0100);
    cmd(4'h3, 3'h0, 4'h0);
    wb(1'b0, 8'h08, 0, '1, 32'h0003_8000);
    cmd(4'h2, 3'h0, 4'h1);
    wb(1'b0, 8'h08, 0, '1, 32'h0003_8018);
    cmd(4'h4, 3'h0, 4'h0);
    cmd(4'h5, 3'h1, 4'h0);
    cmd(4'h7, 3'h4, 4'h5);
    wb(1'b0, 8'h08, 0, '1, 32'h0003_0200);
    pll <= 2'h1;
    for (int i = 0; i < 4; i++) begin
      cmd(4'h7, {1'b1, 2'(i)}, 4'h0);
      `CHK(u_clock_device_model.r[4], {6'h04, 2'(i)})
    end
    cmd(4'h6, 3'h1, 4'h0);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    cmd(4'h2, 3'h1, 4'h2);
    cmd(4'h6, 3'h1, 4'h4);
    wb(1'b0, 8'h08, 0, '1, 32'h0103_0300);
    cmd(4'hF, 3'h0, 4'h6);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, 0, 0);
    wb(1'b0, 8'h20, 0, '1, 32'h0000_0000);
    complete_run();
  end
endmodule : test_clock_source_host
